/* File: verilog/gtl_port.sv */
// Purpose: host-side data path and handshakes of an IEEE 488 talk/listen port
// Assumes: bus pins are open-collector, sampled through two flip-flops
// Notes:   all pin levels are the electrical levels, low = true
//
// Functional notes
// - pass-through register stores nothing; reads show live bus data lines.
// - during a parallel poll drive the stored poll response byte.
// - only hardware reset clears poll response; software reset keeps it.
// - listener latches received byte, flags it, holds NRFD until host reads.
// - NRFD released on read unless holdoff; then release-holdoff command finishes.
// - received and transmit byte registers are independent.
// - transmit byte sent with ATN when controller, without when talker; auto handshake.
// - byte-sent flag on talker entry and after each byte accepted; the code sets it after a byte only when mask bit BO is set.
// - byte held over ATN is sent after ATN drops unless cancelled.
// - bus data inverted; host bit 0 maps to DIO8, bit 7 to DIO1.
// - hardware reset sets soft-reset hold, clears poll, status, commands, idles.
// - interface clear held at least 100 us, then controller active.
// - take control while talking flags unknown command with accept holdoff.
// - controller keeps ATN asserted until release-control or go-to-standby.
// - controller ignores command bytes it sends itself.
// - talk-only command places the device in talker addressed state.
// - listen-only command places the device in listener addressed state.
// - without pass-through select, own talk/listen address addresses the device.
// - mask bits enable routing of unknown commands and secondaries; the code routes only take-control while talker.
// - holdoff-all holds after every byte; holdoff-end only after end message.
// - release-holdoff command clears any ready-for-data holdoff.
// - talk-only and listen-only persist until rewritten with clear bit.
// - cancel-new-byte discards a transmit byte interrupted by ATN.
`timescale 1ns/10ps
module gtl_port
  import gtl_pkg::*;
#(
  parameter logic [4:0] MY_ADDR    = GTL_MY_ADDR_RST,
  parameter int         IFC_CYCLES = GTL_IFC_CYCLES
)(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // host register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // bus pins, input levels
  input  wire logic [7:0] i_dio_n,
  input  wire logic       i_atn_n,
  input  wire logic       i_eoi_n,
  input  wire logic       i_dav_n,
  input  wire logic       i_nrfd_n,
  input  wire logic       i_ndac_n,
  // bus pins, drive: enable high pulls the line low
  output logic      [7:0] o_dio_oe,
  output logic            o_atn_oe,
  output logic            o_dav_oe,
  output logic            o_nrfd_oe,
  output logic            o_ndac_oe,
  output logic            o_ifc_oe
);
  typedef enum {GTL_SRC_IDLE, GTL_SRC_WAIT_RFD, GTL_SRC_SETTLE,
                GTL_SRC_DAV, GTL_SRC_WAIT_DAC} gtl_src_t;
  typedef enum {GTL_ACP_READY, GTL_ACP_ACCEPT, GTL_ACP_HOLD} gtl_acp_t;

  typedef struct packed {
    logic [7:0] s1_dio;  logic [7:0] s2_dio;
    logic [4:0] s1_ctl;  logic [4:0] s2_ctl; // atn eoi dav nrfd ndac, true=1
    logic [7:0] poll_resp;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic       tx_full;
    logic [5:0] mask;
    logic       swrst;
    logic       irq_bi;  logic irq_bo;  logic irq_ucg;
    logic       hdfa;    logic hdfe;    logic rfd_hold; logic dac_hold;
    logic       ton;     logic lon;     logic tads;     logic lads;
    logic       cac;     logic ifc;     logic [15:0] ifc_cnt;
    logic       rqc_pend;
    logic       byte_unread;
    gtl_src_t   src;     logic [3:0] t1_cnt;
    gtl_acp_t   acp;
    logic [7:0] rdata;
    logic [7:0] dio_oe;
    logic       atn_oe;  logic dav_oe;  logic nrfd_oe; logic ndac_oe; logic ifc_oe;
  } gtl_state_t;

  gtl_state_t st_reg;
  gtl_state_t st_next;

  logic       atn_t, eoi_t, dav_t, nrfd_t, ndac_t;
  logic [7:0] bus_byte;
  logic [7:0] cmd_byte;
  logic       talk_act, lstn_act, ppoll;
  logic       aux_wr, cs;
  logic [4:0] aux_code;

  // host bit 0 is the most significant bus line
  function automatic logic [7:0] gtl_swap(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int k = 0; k < 8; k++) r[k] = v[7-k];
    return r;
  endfunction : gtl_swap

  always_comb
  begin
    {atn_t, eoi_t, dav_t, nrfd_t, ndac_t} = st_reg.s2_ctl;
    bus_byte = gtl_swap(~st_reg.s2_dio);
    // command codes are defined in line order, so decode unswapped
    cmd_byte = ~st_reg.s2_dio;
    ppoll    = atn_t && eoi_t && !st_reg.cac;
    talk_act = st_reg.tads && !atn_t;
    lstn_act = st_reg.lads && !atn_t;
    aux_wr   = i_wr && (i_addr == GTL_OFS_AUXCMD);
    cs       = i_wdata[GTL_AUX_CS_BIT];
    aux_code = i_wdata[4:0];
  end

  always_comb
  begin
    st_next = st_reg;
    // ****************************************
    // pin synchronisers
    // ****************************************
    st_next.s1_dio = i_dio_n;
    st_next.s2_dio = st_reg.s1_dio;
    st_next.s1_ctl = ~{i_atn_n, i_eoi_n, i_dav_n, i_nrfd_n, i_ndac_n};
    st_next.s2_ctl = st_reg.s1_ctl;

    // ****************************************
    // host writes
    // ****************************************
    if (i_wr && i_addr == GTL_OFS_POLLRESP) st_next.poll_resp = i_wdata;
    if (i_wr && i_addr == GTL_OFS_INTMASK)  st_next.mask      = i_wdata[5:0];
    if (i_wr && i_addr == GTL_OFS_TXBYTE)
    begin
      st_next.tx_byte = i_wdata;
      st_next.tx_full = 1'b1;
    end
    if (aux_wr)
    begin
      case (aux_code)
        GTL_AUX_SWRST: st_next.swrst = cs;
        GTL_AUX_DACR:  st_next.dac_hold = 1'b0;
        GTL_AUX_RHDF:  st_next.rfd_hold = 1'b0;
        GTL_AUX_HDFA:  st_next.hdfa = cs;
        GTL_AUX_HDFE:  st_next.hdfe = cs;
        GTL_AUX_NBAF:  if (st_reg.src == GTL_SRC_IDLE) st_next.tx_full = 1'b0;
        GTL_AUX_LON:   st_next.lon = cs;
        GTL_AUX_TON:   st_next.ton = cs;
        GTL_AUX_GTS, GTL_AUX_RLC: st_next.atn_oe = 1'b0;
        GTL_AUX_TCA:   if (st_reg.cac) st_next.atn_oe = 1'b1;
        GTL_AUX_SIC:
        begin
          st_next.ifc = cs;
          st_next.ifc_cnt = '0;
        end
        GTL_AUX_RQC:   st_next.rqc_pend = 1'b1;
        default: ;
      endcase
      if (aux_code == GTL_AUX_RLC) st_next.cac = 1'b0;
    end

    // ****************************************
    // interface clear, at least the minimum time
    // ****************************************
    // keep counting after an early clear so the line still meets the minimum
    if ((st_reg.ifc || st_reg.ifc_oe) && st_reg.ifc_cnt < 16'(IFC_CYCLES))
      st_next.ifc_cnt = st_reg.ifc_cnt + 16'h0001;
    if (!st_reg.ifc && st_reg.ifc_oe && st_reg.ifc_cnt >= 16'(IFC_CYCLES))
    begin
      st_next.cac    = 1'b1;
      st_next.atn_oe = 1'b1;
    end
    st_next.ifc_oe = st_reg.ifc || (st_reg.ifc_oe && st_reg.ifc_cnt < 16'(IFC_CYCLES));
    // control passes only once the old controller has dropped ATN
    if (st_reg.rqc_pend && !atn_t)
    begin
      st_next.cac      = 1'b1;
      st_next.atn_oe   = 1'b1;
      st_next.rqc_pend = 1'b0;
    end

    // local addressing follows the hold commands
    st_next.tads = st_reg.ton ? 1'b1 : st_next.tads;
    st_next.lads = st_reg.lon ? 1'b1 : st_next.lads;
    if (aux_wr && aux_code == GTL_AUX_TON && !cs) st_next.tads = 1'b0;
    if (aux_wr && aux_code == GTL_AUX_LON && !cs) st_next.lads = 1'b0;

    // ****************************************
    // acceptor: commands under ATN and data bytes
    // ****************************************
    st_next.ndac_oe = 1'b0;
    st_next.nrfd_oe = 1'b0;
    case (st_reg.acp)
      GTL_ACP_READY:
      begin
        if (dav_t && (lstn_act || (atn_t && !st_reg.cac)))
        begin
          st_next.acp = GTL_ACP_ACCEPT;
          if (atn_t)
          begin
            if (cmd_byte[6:5] == 2'b01 && !st_reg.mask[GTL_MSK_APT])
              st_next.lads = (cmd_byte[4:0] == MY_ADDR) | st_reg.lads;
            if (cmd_byte[6:0] == GTL_CMD_UNL && !st_reg.lon) st_next.lads = 1'b0;
            if (cmd_byte[6:5] == 2'b10 && !st_reg.mask[GTL_MSK_APT])
            begin
              st_next.tads = (cmd_byte[4:0] == MY_ADDR) || st_reg.ton;
              if (cmd_byte[4:0] == MY_ADDR && !st_reg.tads) st_next.irq_bo = 1'b1;
            end
            if (cmd_byte[6:0] == GTL_CMD_TCT && st_reg.tads
                && st_reg.mask[GTL_MSK_UNKNOWN_ADDRESSED_ROUTE])
            begin
              st_next.irq_ucg  = 1'b1;
              st_next.dac_hold = 1'b1;
            end
          end
          else
          begin
            st_next.rx_byte     = bus_byte;
            st_next.irq_bi      = 1'b1;
            st_next.byte_unread = 1'b1;
            if (st_reg.hdfa || (st_reg.hdfe && eoi_t)) st_next.rfd_hold = 1'b1;
          end
        end
      end
      GTL_ACP_ACCEPT:
        if (!dav_t) st_next.acp = GTL_ACP_HOLD;
      GTL_ACP_HOLD:
        if (!st_reg.byte_unread && !st_reg.rfd_hold) st_next.acp = GTL_ACP_READY;
      default: st_next.acp = GTL_ACP_READY;
    endcase
    if (st_reg.acp == GTL_ACP_READY && st_reg.byte_unread) st_next.nrfd_oe = 1'b1;
    if (st_reg.acp != GTL_ACP_READY) st_next.nrfd_oe = 1'b1;
    if ((lstn_act || (atn_t && !st_reg.cac)) &&
        (st_reg.acp == GTL_ACP_READY || st_next.dac_hold)) st_next.ndac_oe = 1'b1;
    if (!(st_reg.lads || atn_t)) st_next.nrfd_oe = 1'b0;

    // ****************************************
    // source handshake
    // ****************************************
    st_next.dav_oe = 1'b0;
    case (st_reg.src)
      GTL_SRC_IDLE:
        if (st_reg.tx_full && (talk_act || st_reg.cac && st_reg.atn_oe))
          st_next.src = GTL_SRC_WAIT_RFD;
      GTL_SRC_WAIT_RFD:
        if (!nrfd_t)
        begin
          st_next.src    = GTL_SRC_SETTLE;
          st_next.t1_cnt = '0;
        end
      GTL_SRC_SETTLE:
      begin
        st_next.t1_cnt = st_reg.t1_cnt + 4'h1;
        if (st_reg.t1_cnt == 4'(GTL_T1_CYCLES - 1)) st_next.src = GTL_SRC_DAV;
      end
      GTL_SRC_DAV:
      begin
        st_next.dav_oe = 1'b1;
        if (!ndac_t)
        begin
          st_next.src     = GTL_SRC_WAIT_DAC;
          st_next.tx_full = 1'b0;
          if (st_reg.mask[GTL_MSK_BO]) st_next.irq_bo = 1'b1;
        end
      end
      GTL_SRC_WAIT_DAC:
        st_next.src = GTL_SRC_IDLE;
      default: st_next.src = GTL_SRC_IDLE;
    endcase
    if (st_reg.src == GTL_SRC_IDLE && !(talk_act || st_reg.cac)) st_next.dio_oe = '0;
    // ****************************************
    // data line drive: poll response or transmit byte
    // ****************************************
    if (ppoll)
      st_next.dio_oe = gtl_swap(st_reg.poll_resp);
    else if (st_reg.src != GTL_SRC_IDLE)
      st_next.dio_oe = gtl_swap(st_reg.tx_byte);
    else
      st_next.dio_oe = '0;
    if (st_reg.ton && !st_reg.tads) st_next.irq_bo = 1'b1;

    // ****************************************
    // host reads, clears after the sets (read clear wins, except a status bit set while it reads 0)
    // ****************************************
    st_next.rdata = '0;
    if (i_rd)
    begin
      case (i_addr)
        GTL_OFS_PASSTHRU: st_next.rdata = bus_byte;
        GTL_OFS_RXBYTE:
        begin
          st_next.rdata = st_reg.rx_byte;
          st_next.byte_unread = 1'b0;
        end
        GTL_OFS_INTMASK:  st_next.rdata = {2'b00, st_reg.mask};
        GTL_OFS_STATUS:
        begin
          st_next.rdata = {1'b0, st_reg.swrst, st_reg.cac, st_reg.lads, st_reg.tads,
                           st_reg.irq_ucg, st_reg.irq_bo, st_reg.irq_bi};
          st_next.irq_bi  = st_next.irq_bi  & ~st_reg.irq_bi | (st_next.irq_bi & ~st_reg.irq_bi);
          st_next.irq_bo  = st_next.irq_bo  & ~st_reg.irq_bo | (st_next.irq_bo & ~st_reg.irq_bo);
          st_next.irq_ucg = st_next.irq_ucg & ~st_reg.irq_ucg;
        end
        default: st_next.rdata = '0;
      endcase
    end
    if (st_reg.swrst)
    begin
      st_next.src = GTL_SRC_IDLE;
      st_next.acp = GTL_ACP_READY;
      st_next.dio_oe = '0;
      st_next.nrfd_oe = 1'b0;
      st_next.ndac_oe = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      st_reg       <= '0;
      st_reg.swrst <= 1'b1;
      st_reg.src   <= GTL_SRC_IDLE;
      st_reg.acp   <= GTL_ACP_READY;
    end
    else
      st_reg <= st_next;
  end

  assign o_rdata   = st_reg.rdata;
  assign o_dio_oe  = st_reg.dio_oe;
  assign o_atn_oe  = st_reg.atn_oe;
  assign o_dav_oe  = st_reg.dav_oe;
  assign o_nrfd_oe = st_reg.nrfd_oe;
  assign o_ndac_oe = st_reg.ndac_oe;
  assign o_ifc_oe  = st_reg.ifc_oe;

  // ****************************************
  // checks
  // ****************************************
  property p_reset_hold;
    @(posedge i_clock) $past(i_rst) |-> st_reg.swrst && st_reg.poll_resp == 8'h00;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset state wrong");

  property p_poll_keep;
    @(posedge i_clock) disable iff (i_rst)
      (aux_wr && aux_code == GTL_AUX_SWRST && !(i_wr && i_addr == GTL_OFS_POLLRESP))
      |=> st_reg.poll_resp == $past(st_reg.poll_resp);
  endproperty
  a_poll_keep: assert property (p_poll_keep) else $error("soft reset touched poll");

  property p_rx_indep;
    @(posedge i_clock) disable iff (i_rst)
      (i_wr && i_addr == GTL_OFS_TXBYTE && st_reg.acp != GTL_ACP_READY)
      |=> st_reg.rx_byte == $past(st_reg.rx_byte);
  endproperty
  a_rx_indep: assert property (p_rx_indep) else $error("tx write changed rx");

  property p_nrfd_hold;
    @(posedge i_clock) disable iff (i_rst)
      (st_reg.byte_unread && st_reg.lads && !st_reg.swrst && !i_rd) |=> o_nrfd_oe;
  endproperty
  a_nrfd_hold: assert property (p_nrfd_hold) else $error("NRFD dropped early");

  property p_ppoll;
    @(posedge i_clock) disable iff (i_rst)
      ppoll |=> o_dio_oe == gtl_swap($past(st_reg.poll_resp));
  endproperty
  a_ppoll: assert property (p_ppoll) else $error("poll byte not driven");

  property p_pass_read;
    @(posedge i_clock) disable iff (i_rst)
      (i_rd && i_addr == GTL_OFS_PASSTHRU) |=> o_rdata == $past(bus_byte);
  endproperty
  a_pass_read: assert property (p_pass_read) else $error("pass-through wrong");

  property p_rhdf;
    @(posedge i_clock) disable iff (i_rst)
      (aux_wr && aux_code == GTL_AUX_RHDF && st_reg.acp != GTL_ACP_READY) |=> !st_reg.rfd_hold;
  endproperty
  a_rhdf: assert property (p_rhdf) else $error("holdoff not released");

  property p_ton;
    @(posedge i_clock) disable iff (i_rst)
      (aux_wr && aux_code == GTL_AUX_TON && cs) |=> ##1 st_reg.tads;
  endproperty
  a_ton: assert property (p_ton) else $error("talk-only not entered");
endmodule : gtl_port

/* File: common/gtl_pkg.sv */
// Purpose: constants for the talk/listen control port
// Assumes: 20 MHz clock, host port with one-cycle read latency
// Notes:   register offsets are word indices on the host port
package gtl_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] GTL_OFS_PASSTHRU = 4'h0;
  localparam logic [3:0] GTL_OFS_POLLRESP = 4'h1;
  localparam logic [3:0] GTL_OFS_RXBYTE   = 4'h2;
  localparam logic [3:0] GTL_OFS_TXBYTE   = 4'h3;
  localparam logic [3:0] GTL_OFS_AUXCMD   = 4'h4;
  localparam logic [3:0] GTL_OFS_INTMASK  = 4'h5;
  localparam logic [3:0] GTL_OFS_STATUS   = 4'h6;
  // ****************************************
  // auxiliary command word: bit 7 is clear/set, bits 4:0 code
  // ****************************************
  localparam int         GTL_AUX_CS_BIT = 7;
  localparam logic [4:0] GTL_AUX_SWRST  = 5'h00;
  localparam logic [4:0] GTL_AUX_DACR   = 5'h01;
  localparam logic [4:0] GTL_AUX_RHDF   = 5'h02;
  localparam logic [4:0] GTL_AUX_HDFA   = 5'h03;
  localparam logic [4:0] GTL_AUX_HDFE   = 5'h04;
  localparam logic [4:0] GTL_AUX_NBAF   = 5'h05;
  localparam logic [4:0] GTL_AUX_LON    = 5'h09;
  localparam logic [4:0] GTL_AUX_TON    = 5'h0A;
  localparam logic [4:0] GTL_AUX_GTS    = 5'h0B;
  localparam logic [4:0] GTL_AUX_TCA    = 5'h0C;
  localparam logic [4:0] GTL_AUX_SIC    = 5'h0F;
  localparam logic [4:0] GTL_AUX_RQC    = 5'h11;
  localparam logic [4:0] GTL_AUX_RLC    = 5'h12;
  // ****************************************
  // interrupt mask bits (route enables and irq enables)
  // ****************************************
  localparam int GTL_MSK_BI   = 0;
  localparam int GTL_MSK_BO   = 1;
  localparam int GTL_MSK_UCG  = 2;
  localparam int GTL_MSK_UNKNOWN_UNIVERSAL_ROUTE = 3;
  localparam int GTL_MSK_UNKNOWN_ADDRESSED_ROUTE = 4;
  localparam int GTL_MSK_APT  = 5;
  // ****************************************
  // status bits
  // ****************************************
  localparam int GTL_ST_BI   = 0;
  localparam int GTL_ST_BO   = 1;
  localparam int GTL_ST_UCG  = 2;
  localparam int GTL_ST_TALK = 3;
  localparam int GTL_ST_LSTN = 4;
  localparam int GTL_ST_CTRL = 5;
  localparam int GTL_ST_SWRST= 6;
  // ****************************************
  // bus command encodings (7-bit, top bit ignored)
  // ****************************************
  localparam logic [6:0] GTL_CMD_UNL = 7'h3F;
  localparam logic [6:0] GTL_CMD_UNT = 7'h5F;
  localparam logic [6:0] GTL_CMD_TCT = 7'h09;
  localparam logic [6:0] GTL_CMD_GET = 7'h08;
  localparam logic [6:0] GTL_CMD_DCL = 7'h14;
  // ****************************************
  // timing
  // ****************************************
  localparam int GTL_CLK_HZ     = 20_000_000;
  localparam int GTL_IFC_MIN_US = 100;
  localparam int GTL_IFC_CYCLES = (GTL_IFC_MIN_US * (GTL_CLK_HZ / 1_000_000));
  localparam int GTL_T1_CYCLES  = 10;
  localparam logic [4:0] GTL_MY_ADDR_RST = 5'h00;
endpackage : gtl_pkg

/* File: verif/gtl_bus_partner.sv */
// Purpose: behavioural far-side instrument for the talk/listen port
// Assumes: open-collector lines with pull-ups, enable high pulls low
// Notes:   data vectors are true levels, bit0 = DIO1
`timescale 1ns/10ps
module gtl_bus_partner (
  // clock
  input  wire logic       i_clock,
  // line levels seen
  input  wire logic [7:0] i_dio_n,
  input  wire logic       i_atn_n,
  input  wire logic       i_dav_n,
  input  wire logic       i_nrfd_n,
  input  wire logic       i_ndac_n,
  // line pulls
  output logic      [7:0] o_dio_oe,
  output logic            o_atn_oe,
  output logic            o_eoi_oe,
  output logic            o_dav_oe,
  output logic            o_nrfd_oe,
  output logic            o_ndac_oe
);
  initial {o_dio_oe, o_atn_oe, o_eoi_oe, o_dav_oe, o_nrfd_oe, o_ndac_oe} = '0;
  // ****************************************
  // handshakes
  // ****************************************
  task automatic ctl(input logic a, input logic e);
    @(posedge i_clock);
    o_atn_oe <= a;
    o_eoi_oe <= e;
  endtask : ctl
  task automatic talk(input logic [7:0] t, output logic ok);
    int n;
    for (n = 0; n < 400 && i_nrfd_n !== 1'b1; n++) @(posedge i_clock);
    @(posedge i_clock);
    o_dio_oe <= t;
    repeat (3) @(posedge i_clock);
    o_dav_oe <= 1'b1;
    for (n = 0; n < 400 && i_ndac_n !== 1'b1; n++) @(posedge i_clock);
    ok = (n < 400);
    // released lines float high through the pull-ups
    o_dav_oe <= 1'b0;
    o_dio_oe <= '0;
  endtask : talk
  task automatic listen(input int dly, output logic [7:0] t, output logic a, output logic ok);
    int n;
    @(posedge i_clock);
    o_ndac_oe <= 1'b1;
    for (n = 0; n < 400 && i_dav_n !== 1'b0; n++) @(posedge i_clock);
    ok = (n < 400);
    t = ~i_dio_n;
    a = ~i_atn_n;
    o_nrfd_oe <= 1'b1;
    // slow acceptor keeps the talker waiting
    repeat (dly) @(posedge i_clock);
    o_ndac_oe <= 1'b0;
    for (n = 0; n < 400 && i_dav_n !== 1'b1; n++) @(posedge i_clock);
    o_nrfd_oe <= 1'b0;
  endtask : listen
endmodule : gtl_bus_partner

/* File: verif/ieee488_talk_listen_control_port_bench.sv */
// Purpose: self-checking bench for the talk/listen control port
// Assumes: partner model stands in for the other instruments
// Notes:   short interface clear count keeps the run brief
`timescale 1ns/10ps
module ieee488_talk_listen_control_port_bench;
  import gtl_pkg::*;
  localparam int         IFC = 20;
  localparam logic [4:0] MY  = 5'h0B;
  logic       clock = 1'b0;
  logic       rst   = 1'b1;
  logic [3:0] addr  = '0;
  logic [7:0] wdata = '0;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic [7:0] rdata, d_dio, p_dio, got;
  logic       d_atn, d_dav, d_nrfd, d_ndac, d_ifc, p_atn, p_eoi, p_dav, p_nrfd, p_ndac;
  logic       got_atn, ok;
  int         n;
  int         miscompares = 0;
  int         tests_run   = 0;
  always #25 clock = ~clock;
  gtl_port #(.MY_ADDR(MY), .IFC_CYCLES(IFC)) u_dut (
    .i_clock(clock), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_dio_n(~(d_dio | p_dio)), .i_atn_n(~(d_atn | p_atn)),
    .i_eoi_n(~p_eoi), .i_dav_n(~(d_dav | p_dav)), .i_nrfd_n(~(d_nrfd | p_nrfd)),
    .i_ndac_n(~(d_ndac | p_ndac)), .o_dio_oe(d_dio), .o_atn_oe(d_atn), .o_dav_oe(d_dav),
    .o_nrfd_oe(d_nrfd), .o_ndac_oe(d_ndac), .o_ifc_oe(d_ifc));
  gtl_bus_partner u_p (
    .i_clock(clock), .i_dio_n(~(d_dio | p_dio)), .i_atn_n(~(d_atn | p_atn)),
    .i_dav_n(~(d_dav | p_dav)), .i_nrfd_n(~(d_nrfd | p_nrfd)), .i_ndac_n(~(d_ndac | p_ndac)),
    .o_dio_oe(p_dio), .o_atn_oe(p_atn), .o_eoi_oe(p_eoi), .o_dav_oe(p_dav),
    .o_nrfd_oe(p_nrfd), .o_ndac_oe(p_ndac));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] rev(input logic [7:0] h);
    return {<<{h}};
  endfunction : rev
  function automatic logic [7:0] bv(input int b);
    return 8'h01 << b;
  endfunction : bv
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic chkb(input string nm, input logic e, input logic s);
    chk(nm, {7'h00, e}, {7'h00, s});
  endtask : chkb
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : reg_wr
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e,
                        input logic [7:0] m);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 chk(nm, e, rdata & m);
  endtask : rd_chk
  task automatic aux(input logic cs, input logic [4:0] c);
    reg_wr(GTL_OFS_AUXCMD, {cs, 2'b00, c});
  endtask : aux
  task automatic hw_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    aux(1'b0, GTL_AUX_SWRST);
  endtask : hw_reset
  task automatic give_verdict();
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_reset();
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    #1 chk("pins", 8'h00, d_dio | {3'b000, d_atn, d_dav, d_nrfd, d_ndac, d_ifc});
    rd_chk("status", GTL_OFS_STATUS, bv(GTL_ST_SWRST), 8'hFF);
    aux(1'b0, GTL_AUX_SWRST);
    reg_wr(GTL_OFS_INTMASK, 8'h07);
    rd_chk("unmapped", 4'hF, 8'h00, 8'hFF);
    u_p.ctl(1'b1, 1'b0);
    u_p.talk({3'b001, MY}, ok);
    rd_chk("own listen", GTL_OFS_STATUS, bv(GTL_ST_LSTN), bv(GTL_ST_LSTN));
    u_p.talk({1'b0, GTL_CMD_UNL}, ok);
    u_p.ctl(1'b0, 1'b0);
  endtask : s_reset
  task automatic s_listen();
    aux(1'b1, GTL_AUX_LON);
    u_p.talk(rev(8'hA5), ok);
    chkb("talk done", 1'b1, ok);
    repeat (4) @(posedge clock);
    chkb("nrfd held", 1'b1, d_nrfd);
    rd_chk("bi", GTL_OFS_STATUS, bv(GTL_ST_BI), bv(GTL_ST_BI));
    rd_chk("rx", GTL_OFS_RXBYTE, 8'hA5, 8'hFF);
    for (n = 0; n < 50 && d_nrfd !== 1'b0; n++) @(posedge clock);
    chkb("nrfd free", 1'b0, d_nrfd);
    aux(1'b1, GTL_AUX_HDFA);
    u_p.talk(rev(8'h3C), ok);
    rd_chk("rx", GTL_OFS_RXBYTE, 8'h3C, 8'hFF);
    // holdoff must outlast the read
    repeat (20) @(posedge clock);
    chkb("holdoff", 1'b1, d_nrfd);
    aux(1'b0, GTL_AUX_RHDF);
    for (n = 0; n < 50 && d_nrfd !== 1'b0; n++) @(posedge clock);
    chkb("released", 1'b0, d_nrfd);
    aux(1'b0, GTL_AUX_HDFA);
    aux(1'b0, GTL_AUX_LON);
    rd_chk("lon off", GTL_OFS_STATUS, 8'h00, bv(GTL_ST_LSTN));
  endtask : s_listen
  task automatic s_talk();
    aux(1'b1, GTL_AUX_TON);
    rd_chk("ton", GTL_OFS_STATUS, 8'h0A, 8'h0A);
    fork
      u_p.listen(0, got, got_atn, ok);
      reg_wr(GTL_OFS_TXBYTE, 8'h6D);
    join
    chk("tx", rev(8'h6D), got);
    chkb("tx atn", 1'b0, got_atn);
    rd_chk("bo", GTL_OFS_STATUS, bv(GTL_ST_BO), bv(GTL_ST_BO));
    rd_chk("rx kept", GTL_OFS_RXBYTE, 8'h3C, 8'hFF);
    u_p.ctl(1'b1, 1'b0);
    reg_wr(GTL_OFS_TXBYTE, 8'h81);
    repeat (30) @(posedge clock);
    chkb("dav in atn", 1'b0, d_dav);
    fork
      u_p.listen(8, got, got_atn, ok);
      u_p.ctl(1'b0, 1'b0);
    join
    chk("held byte", rev(8'h81), got);
    u_p.ctl(1'b1, 1'b0);
    reg_wr(GTL_OFS_TXBYTE, 8'h42);
    aux(1'b0, GTL_AUX_NBAF);
    fork
      u_p.listen(0, got, got_atn, ok);
      u_p.ctl(1'b0, 1'b0);
    join
    chkb("cancelled", 1'b0, ok);
  endtask : s_talk
  task automatic s_poll();
    reg_wr(GTL_OFS_POLLRESP, 8'hC4);
    aux(1'b1, GTL_AUX_SWRST);
    aux(1'b0, GTL_AUX_SWRST);
    u_p.ctl(1'b1, 1'b1);
    for (n = 0; n < 50 && d_dio !== rev(8'hC4); n++) @(posedge clock);
    chk("poll", rev(8'hC4), d_dio);
    u_p.ctl(1'b0, 1'b0);
    hw_reset();
    u_p.ctl(1'b1, 1'b1);
    repeat (10) @(posedge clock);
    chk("poll cleared", 8'h00, d_dio);
    u_p.ctl(1'b0, 1'b0);
  endtask : s_poll
  task automatic s_ctrl();
    reg_wr(GTL_OFS_INTMASK, 8'h17);
    aux(1'b1, GTL_AUX_TON);
    u_p.ctl(1'b1, 1'b0);
    fork
      u_p.talk({1'b0, GTL_CMD_TCT}, ok);
      begin
        for (n = 0; n < 50 && p_dav !== 1'b1; n++) @(posedge clock);
        repeat (6) @(posedge clock);
        rd_chk("cpt", GTL_OFS_PASSTHRU, rev({1'b0, GTL_CMD_TCT}), 8'hFF);
        rd_chk("ucg", GTL_OFS_STATUS, bv(GTL_ST_UCG), bv(GTL_ST_UCG));
        aux(1'b0, GTL_AUX_RQC);
        aux(1'b0, GTL_AUX_DACR);
      end
    join
    u_p.ctl(1'b0, 1'b0);
    for (n = 0; n < 50 && d_atn !== 1'b1; n++) @(posedge clock);
    rd_chk("cic", GTL_OFS_STATUS, bv(GTL_ST_CTRL), bv(GTL_ST_CTRL));
    fork
      u_p.listen(0, got, got_atn, ok);
      reg_wr(GTL_OFS_TXBYTE, rev({1'b0, GTL_CMD_UNL}));
    join
    chk("cmd", {1'b0, GTL_CMD_UNL}, got);
    chkb("cmd atn", 1'b1, got_atn);
    repeat (10) @(posedge clock);
    chkb("atn kept", 1'b1, d_atn);
    aux(1'b0, GTL_AUX_GTS);
    for (n = 0; n < 50 && d_atn !== 1'b0; n++) @(posedge clock);
    chkb("standby", 1'b0, d_atn);
  endtask : s_ctrl
  task automatic s_ifc();
    hw_reset();
    aux(1'b1, GTL_AUX_SIC);
    for (n = 0; n < 10 && d_ifc !== 1'b1; n++) @(posedge clock);
    fork
      for (n = 0; n < 200 && d_ifc === 1'b1; n++) @(posedge clock);
      begin
        repeat (IFC) @(posedge clock);
        aux(1'b0, GTL_AUX_SIC);
      end
    join
    chkb("ifc ends", 1'b1, n < 200);
    chkb("ifc time", 1'b1, n >= IFC);
    rd_chk("cac", GTL_OFS_STATUS, bv(GTL_ST_CTRL), bv(GTL_ST_CTRL));
  endtask : s_ifc
  initial
  begin
    s_reset();
    s_listen();
    s_talk();
    s_poll();
    s_ctrl();
    s_ifc();
    give_verdict();
  end
  initial
  begin
    repeat (100000) @(posedge clock);
    miscompares++;
    give_verdict();
  end
endmodule : ieee488_talk_listen_control_port_bench
